//--- verilog/pwr_wake_pkg.sv
// Constants and types for the power button and wake controller
// Summary of operation
// (R01) Short press from soft-off or sleep brings the system to working.
// (R02) Short press while working moves the system into the sleeping state.
// (R03) Press over six seconds while working or sleeping forces soft-off.
// (R04) Switch, alarm, network, PME and WAKE wake from S3, S4 and S5.
// (R05) USB activity wakes only from S3, never from S4 or S5.
// (R06) Infrared activity wakes from S3, S4 and S5.
// (R07) In S3, S4, S5 only wake logic stays powered; devices held in D3.
// (R08) Four states kept: S0 working, S3 RAM, S4 disk, S5 soft-off.
// (R09) Software power-off command removes power and enters soft-off.
// (R10) Closed intrusion switch means cover removed; report chassis opened.
// (R11) Switches debounced; presses between four and six seconds are ignored.
// (R12) PME wakes from S3, S4, S5 only when wake-on-PME is enabled.
package pwr_wake_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned SHORT_MS = 4000;
  localparam int unsigned LONG_MS = 6000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS;
  localparam int unsigned SHORT_TICKS = SHORT_MS;
  localparam int unsigned LONG_TICKS = LONG_MS;
  localparam int unsigned TICK_W = 18;
  localparam int unsigned HOLD_W = 13;
  localparam logic [1:0] SW_REQ_NONE = 2'h0;
  localparam logic [1:0] SW_REQ_S3 = 2'h1;
  localparam logic [1:0] SW_REQ_S4 = 2'h2;
  localparam logic [1:0] SW_REQ_OFF = 2'h3;

  typedef enum logic [1:0] {ST_S0, ST_S3, ST_S4, ST_S5} sleep_state_t;

  typedef struct packed {
    logic rtc_alarm;
    logic lan;
    logic usb;
    logic pme;
    logic pcie_wake;
    logic cir;
  } wake_src_t;
endpackage

//--- verilog/power_button_wake_control.sv
// Power switch timing, sleep state control, wake gating and intrusion latch
`timescale 1ns/100ps
module power_button_wake_control
  import pwr_wake_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pwr_sw_n,
  input wire logic intrusion_closed,
  input wire wake_src_t wake_n,
  input wire logic wake_on_pme_en,
  input wire logic [1:0] sw_req,
  input wire logic sw_req_valid,
  input wire logic intrusion_clear,
  output logic main_power_on,
  output logic devices_d0,
  output logic [1:0] sleep_state,
  output logic chassis_opened
);
  // Two-flop synchronisers for all pin inputs
  logic [1:0] sw_sync_q;
  logic [1:0] int_sync_q;
  wake_src_t wake_s1_q;
  wake_src_t wake_s2_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_sync_q <= 2'h0;
      int_sync_q <= 2'h0;
      wake_s1_q <= '0;
      wake_s2_q <= '0;
    end else begin
      sw_sync_q <= {sw_sync_q[0], ~pwr_sw_n};
      int_sync_q <= {int_sync_q[0], intrusion_closed};
      wake_s1_q <= ~wake_n;
      wake_s2_q <= wake_s1_q;
    end
  end

  // Millisecond tick enable
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  wire tick_wrap = (tick_cnt_q == TICK_W'(TICK_DIV - 1));
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
      tick_q <= tick_wrap;
    end
  end

  // Debounce: level must stay stable for the debounce time to be taken
  logic sw_db_q, int_db_q;
  logic [4:0] sw_db_cnt_q, int_db_cnt_q;
  wire sw_diff = sw_sync_q[1] != sw_db_q;
  wire int_diff = int_sync_q[1] != int_db_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_db_q <= 1'b0;
      int_db_q <= 1'b0;
      sw_db_cnt_q <= '0;
      int_db_cnt_q <= '0;
    end else begin
      if (!sw_diff) sw_db_cnt_q <= '0; // R11
      else if (tick_q) sw_db_cnt_q <= sw_db_cnt_q + 1'b1;
      if (sw_diff && tick_q && sw_db_cnt_q == 5'(DEBOUNCE_TICKS - 1)) sw_db_q <= ~sw_db_q;
      if (!int_diff) int_db_cnt_q <= '0; // R11
      else if (tick_q) int_db_cnt_q <= int_db_cnt_q + 1'b1;
      if (int_diff && tick_q && int_db_cnt_q == 5'(DEBOUNCE_TICKS - 1)) int_db_q <= ~int_db_q;
    end
  end

  // Press duration; saturates at the long threshold
  logic [HOLD_W-1:0] hold_q;
  logic sw_prev_q;
  logic long_done_q;
  wire press_end = sw_prev_q && !sw_db_q;
  wire hold_long = hold_q >= HOLD_W'(LONG_TICKS);
  wire short_press = press_end && (hold_q < HOLD_W'(SHORT_TICKS));
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
      sw_prev_q <= 1'b0;
    end else begin
      sw_prev_q <= sw_db_q;
      if (!sw_db_q) hold_q <= '0;
      else if (tick_q && !hold_long) hold_q <= hold_q + 1'b1;
    end
  end

  // Wake gating per sleep state
  sleep_state_t state_q, state_d;
  wire asleep = state_q != ST_S0;
  wire wake_any = wake_s2_q.rtc_alarm || wake_s2_q.lan || wake_s2_q.pcie_wake // R04
               || (wake_s2_q.pme && wake_on_pme_en) // R12
               || (wake_s2_q.usb && state_q == ST_S3) // R05
               || wake_s2_q.cir; // R06
  wire wake_hit = asleep && wake_any;
  wire sw_off = sw_req_valid && sw_req == SW_REQ_OFF;
  wire sw_s3 = sw_req_valid && sw_req == SW_REQ_S3;
  wire sw_s4 = sw_req_valid && sw_req == SW_REQ_S4;
  // A long hold forces off once; the release that follows is not a short press
  wire force_off = sw_db_q && hold_long && !long_done_q && state_q != ST_S5;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_S0: begin
        if (force_off || sw_off) state_d = ST_S5; // R03 R09
        else if (short_press) state_d = ST_S3; // R02
        else if (sw_s3) state_d = ST_S3;
        else if (sw_s4) state_d = ST_S4;
      end
      ST_S3, ST_S4: begin
        if (force_off) state_d = ST_S5; // R03
        else if (short_press || wake_hit) state_d = ST_S0; // R01 R04
      end
      ST_S5: begin
        if (short_press || wake_hit) state_d = ST_S0; // R01 R04
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_S5;
      long_done_q <= 1'b0;
      main_power_on <= 1'b0;
      devices_d0 <= 1'b0;
      sleep_state <= 2'h3;
      chassis_opened <= 1'b0;
    end else begin
      state_q <= state_d; // R08
      if (!sw_db_q) long_done_q <= 1'b0;
      else if (force_off || hold_long) long_done_q <= 1'b1; // R11
      main_power_on <= state_d == ST_S0; // R07 R09
      devices_d0 <= state_d == ST_S0; // R07
      sleep_state <= state_d;
      // Intrusion set wins over a clear in the same cycle
      if (int_db_q) chassis_opened <= 1'b1; // R10
      else if (intrusion_clear) chassis_opened <= 1'b0;
    end
  end

  // A release after a long hold stays clear of the short press window
  wire long_release_ignored = press_end && long_done_q;

  a_power_follows_state: assert property (@(posedge core_clk) disable iff (!nrst)
    main_power_on == (sleep_state == 2'h0)) // R07
    else $error("main power does not follow working state");
  a_devices_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    devices_d0 == main_power_on) // R07
    else $error("devices not in D3 while asleep");
  a_short_wake: assert property (@(posedge core_clk) disable iff (!nrst)
    (short_press && asleep && !force_off) |=> state_q == ST_S0) // R01
    else $error("short press did not wake");
  a_short_sleep: assert property (@(posedge core_clk) disable iff (!nrst)
    (short_press && state_q == ST_S0 && !sw_off) |=> state_q == ST_S3) // R02
    else $error("short press did not sleep");
  a_long_off: assert property (@(posedge core_clk) disable iff (!nrst)
    force_off |=> state_q == ST_S5 && !main_power_on) // R03
    else $error("long press did not force off");
  a_usb_s4_block: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == ST_S4 && !short_press && !force_off && !wake_any) |=> state_q == ST_S4) // R05
    else $error("S4 left without wake cause");
  a_pme_gated: assert property (@(posedge core_clk) disable iff (!nrst)
    (asleep && wake_s2_q.pme && wake_on_pme_en && !force_off) |=> state_q == ST_S0) // R12
    else $error("enabled PME did not wake");
  a_sw_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == ST_S0 && sw_off) |=> state_q == ST_S5 && !main_power_on) // R09
    else $error("software off ignored");
  a_intrusion_set: assert property (@(posedge core_clk) disable iff (!nrst)
    int_db_q |=> chassis_opened) // R10
    else $error("intrusion not reported");
  a_mid_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
    (press_end && !short_press && !long_done_q && !sw_req_valid && !wake_hit)
      |=> $stable(state_q)) // R11
    else $error("mid-length press changed state");
  a_long_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (long_release_ignored && !wake_hit && !sw_req_valid) |=> $stable(state_q)) // R11
    else $error("release after long hold acted");
endmodule

//--- tb/front_panel_model.sv
// Model of the power switch, intrusion switch and wake sources
`timescale 1ns/100ps
module front_panel_model
  import pwr_wake_pkg::*;
(
  input wire logic core_clk,
  output logic pwr_sw_n,
  output logic intrusion_closed,
  output wake_src_t wake_n
);
  // Power switch and wake lines are pulled up, so a released line reads high
  initial begin
    pwr_sw_n = 1'b1;
    intrusion_closed = 1'b0;
    wake_n = '1;
  end
  task automatic press(input int cycles);
    @(posedge core_clk) pwr_sw_n <= 1'b0;
    repeat (cycles) @(posedge core_clk);
    pwr_sw_n <= 1'b1;
  endtask
  task automatic wake(input int idx, input int cycles);
    wake_src_t w;
    w = '1;
    w[idx] = 1'b0;
    @(posedge core_clk) wake_n <= w;
    repeat (cycles) @(posedge core_clk);
    wake_n <= '1;
  endtask
  task automatic set_cover(input logic closed);
    @(posedge core_clk) intrusion_closed <= closed;
  endtask
endmodule

//--- tb/test_power_button_wake_control.sv
// Self-checking bench for the power button and wake controller
`timescale 1ns/100ps
module test_power_button_wake_control;
  import pwr_wake_pkg::*;
  // Short tick keeps the six second hold near 24000 cycles
  localparam int unsigned TD = 4;
  logic core_clk = 1'b0;
  logic nrst;
  logic pwr_sw_n, intrusion_closed, main_power_on, devices_d0, chassis_opened;
  wake_src_t wake_n;
  logic wake_on_pme_en;
  logic intrusion_clear;
  logic sw_req_valid;
  logic [1:0] sw_req;
  logic [1:0] sleep_state;
  int num_errors = 0;
  int num_checks = 0;
  always #2 core_clk = ~core_clk;
  power_button_wake_control #(.TICK_DIV(TD)) power_button_wake_control_i (
    .core_clk(core_clk), .nrst(nrst), .pwr_sw_n(pwr_sw_n),
    .intrusion_closed(intrusion_closed), .wake_n(wake_n), .wake_on_pme_en(wake_on_pme_en),
    .sw_req(sw_req), .sw_req_valid(sw_req_valid), .intrusion_clear(intrusion_clear),
    .main_power_on(main_power_on), .devices_d0(devices_d0), .sleep_state(sleep_state),
    .chassis_opened(chassis_opened));
  front_panel_model front_panel_model_i (.core_clk(core_clk), .pwr_sw_n(pwr_sw_n),
    .intrusion_closed(intrusion_closed), .wake_n(wake_n));
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // A wait that runs out leaves the state wrong, so the check counts it
  task automatic wait_for(input logic [1:0] exp, input int bound);
    int n;
    n = 0;
    // Step off the edge so the registered outputs have settled
    #1;
    while (sleep_state !== exp && n < bound) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("sleep_state", sleep_state, exp);
    check("main_power_on", {1'b0, main_power_on}, {1'b0, exp == ST_S0});
    check("devices_d0", {1'b0, devices_d0}, {1'b0, exp == ST_S0});
    if (sleep_state !== exp) wrap_up();
  endtask
  task automatic stay(input logic [1:0] exp, input int n);
    repeat (n) @(posedge core_clk);
    wait_for(exp, 1);
  endtask
  task automatic sw_cmd(input logic [1:0] req);
    @(posedge core_clk);
    sw_req <= req;
    sw_req_valid <= 1'b1;
    @(posedge core_clk);
    sw_req_valid <= 1'b0;
  endtask
  task automatic t_press();
    front_panel_model_i.press(400);
    wait_for(ST_S0, 200);
    front_panel_model_i.press(400);
    wait_for(ST_S3, 200);
    front_panel_model_i.press(TD * 5000);
    stay(ST_S3, 400);
    front_panel_model_i.press(400);
    wait_for(ST_S0, 200);
  endtask
  // Sleep commands share the state encoding, so cmd doubles as the expected state
  task automatic t_wake();
    logic [1:0] cmd [3] = '{SW_REQ_S3, SW_REQ_S4, SW_REQ_OFF};
    int src [4] = '{0, 1, 4, 5};
    foreach (cmd[i]) begin
      foreach (src[j]) begin
        sw_cmd(cmd[i]);
        wait_for(cmd[i], 8);
        front_panel_model_i.wake(src[j], 20);
        wait_for(ST_S0, 40);
      end
    end
  endtask
  task automatic t_gated();
    sw_cmd(SW_REQ_S4);
    front_panel_model_i.wake(3, 40);
    stay(ST_S4, 20);
    front_panel_model_i.wake(2, 40);
    stay(ST_S4, 20);
    @(posedge core_clk) wake_on_pme_en <= 1'b1;
    front_panel_model_i.wake(2, 20);
    wait_for(ST_S0, 40);
    sw_cmd(SW_REQ_S3);
    front_panel_model_i.wake(3, 20);
    wait_for(ST_S0, 40);
  endtask
  task automatic t_off();
    sw_cmd(SW_REQ_OFF);
    wait_for(ST_S5, 4);
    sw_cmd(SW_REQ_S3);
    stay(ST_S5, 4);
    front_panel_model_i.press(400);
    wait_for(ST_S0, 200);
    front_panel_model_i.press(TD * 6100);
    stay(ST_S5, 0);
    stay(ST_S5, 400);
  endtask
  task automatic t_intr();
    check("chassis_opened", {1'b0, chassis_opened}, 2'h0);
    front_panel_model_i.set_cover(1'b1);
    repeat (120) @(posedge core_clk);
    intrusion_clear <= 1'b1;
    @(posedge core_clk) intrusion_clear <= 1'b0;
    #1 check("chassis_opened", {1'b0, chassis_opened}, 2'h1);
    front_panel_model_i.set_cover(1'b0);
    repeat (120) @(posedge core_clk);
    intrusion_clear <= 1'b1;
    @(posedge core_clk) intrusion_clear <= 1'b0;
    @(posedge core_clk) #1 check("chassis_opened", {1'b0, chassis_opened}, 2'h0);
  endtask
  initial begin
    nrst <= 1'b0;
    wake_on_pme_en <= 1'b0;
    intrusion_clear <= 1'b0;
    sw_req_valid <= 1'b0;
    sw_req <= SW_REQ_NONE;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    stay(ST_S5, 1);
    t_intr();
    t_press();
    t_wake();
    t_gated();
    t_off();
    wrap_up();
  end
endmodule
